// file: hdl/baud_gen_pkg.sv
// Package: register map, field positions, reset values and mode constants
// for the serial baud rate generator.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.

package baud_gen_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] RCV_CTRL_IDX = 8'h18;
    localparam logic [7:0] XMT_CTRL_IDX = 8'h98;
    localparam logic [7:0] DIVISOR_IDX = 8'h99;
    localparam logic [11:0] RCV_CTRL_ADDR = 12'(4 * RCV_CTRL_IDX);
    localparam logic [11:0] XMT_CTRL_ADDR = 12'(4 * XMT_CTRL_IDX);
    localparam logic [11:0] DIVISOR_ADDR = 12'(4 * DIVISOR_IDX);
    localparam logic [11:0] STATUS_ADDR = 12'h400;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int XMT_MASTER_BIT = 7;
    localparam int XMT_SYNC_BIT = 4;
    localparam int XMT_HIGH_SPEED_BIT = 2;
    localparam int XMT_EMPTY_BIT = 1;
    localparam int RCV_PORT_EN_BIT = 7;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] XMT_CTRL_RESET = 8'h02;
    localparam logic [7:0] XMT_CTRL_WMASK = 8'hF5;
    localparam logic [7:0] RCV_CTRL_RESET = 8'h00;
    localparam logic [7:0] RCV_CTRL_WMASK = 8'hF8;
    localparam logic [7:0] DIVISOR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Terminal counts of the prescale stage (divide ratio is value plus one)
    // ------------------------------------------------------------
    localparam logic [5:0] PRE_LOW_SPEED = 6'h3F;
    localparam logic [5:0] PRE_HIGH_SPEED = 6'h0F;
    localparam logic [5:0] PRE_SYNC = 6'h03;
    localparam int VOTE_SAMPLES = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_ASYNC_LOW,
        MODE_ASYNC_HIGH,
        MODE_SYNC_MASTER,
        MODE_SYNC_SLAVE
    } rate_mode_t;

endpackage : baud_gen_pkg

// file: hdl/serial_baud_rate_generator.sv
// Serial baud rate generator with AXI4-Lite registers and receive
// majority detector.
// Assumes clk at 200 MHz stands for the oscillator; rst synchronous high.
// Assumes shift_empty comes from a transmitter outside this block and
// that the receive pin is already synchronous to clk.
//
// Notes on behaviour
// R01: Free-running 8-bit timer, period from divisor
// R02: Async low speed: clock over 64(X+1)
// R03: Async high speed: clock over 16(X+1)
// R04: Sync mode: clock over 4(X+1)
// R05: High-speed select ignored in sync mode
// R06: High-speed select is transmit control bit 2
// R07: Sync rate applies only as internal-clock master; async rates ignore the master bit
// R08: Divisor write clears the generator timer
// R09: Divisor accepts any value 0 to 255
// R10: Divisor clears to zero on reset
// R11: Receive pin level by three-sample majority
// R12: Software picks nearest divisor, prefers high speed
// R13: Async tick is 16x or 64x sample clock
// R14: Sync bit 4 cleared selects async mode
// R15: Tick at terminal count, reload, repeat
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module serial_baud_rate_generator #(
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic receive_data_pin, // Receive data pin level
    input wire logic shift_empty, // Transmit shift register empty
    output logic sample_tick, // One-cycle rate tick
    output logic rx_level // Voted receive level
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int VOTE_N = baud_gen_pkg::VOTE_SAMPLES;

    typedef struct packed {
        logic [7:0] xmt_ctrl;
        logic [7:0] rcv_ctrl;
        logic [DIV_WIDTH-1:0] divisor;
        logic [5:0] pre_cnt;
        logic [DIV_WIDTH-1:0] div_cnt;
        logic tick;
        logic [VOTE_N-1:0] samples;
        logic level;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;
    baud_gen_pkg::rate_mode_t mode;
    logic [5:0] pre_top;
    logic do_write;
    logic do_read;
    logic running;
    logic pre_wrap;
    logic div_wrap;
    logic wr_xmt_sel;
    logic wr_rcv_sel;
    logic wr_div_sel;
    logic wr_mapped;
    logic [7:0] xmt_wval;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic vote;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        if (!cur_ff.xmt_ctrl[baud_gen_pkg::XMT_SYNC_BIT]) begin // R14
            mode = cur_ff.xmt_ctrl[baud_gen_pkg::XMT_HIGH_SPEED_BIT] ? // R06
                baud_gen_pkg::MODE_ASYNC_HIGH : baud_gen_pkg::MODE_ASYNC_LOW;
        end else if (cur_ff.xmt_ctrl[baud_gen_pkg::XMT_MASTER_BIT]) begin
            mode = baud_gen_pkg::MODE_SYNC_MASTER; // R05
        end else begin
            mode = baud_gen_pkg::MODE_SYNC_SLAVE;
        end
        case (mode)
            baud_gen_pkg::MODE_ASYNC_LOW: begin
                pre_top = baud_gen_pkg::PRE_LOW_SPEED; // R02
            end
            baud_gen_pkg::MODE_ASYNC_HIGH: begin
                pre_top = baud_gen_pkg::PRE_HIGH_SPEED; // R03
            end
            baud_gen_pkg::MODE_SYNC_MASTER: begin
                pre_top = baud_gen_pkg::PRE_SYNC; // R04
            end
            default: begin
                pre_top = baud_gen_pkg::PRE_SYNC;
            end
        endcase
        // External clock in sync slave: the generator stands still
        running = (mode != baud_gen_pkg::MODE_SYNC_SLAVE); // R07
    end

    // ------------------------------------------------------------
    // Rate timer limits
    // ------------------------------------------------------------
    // Compared with >= so a count above a freshly lowered limit wraps at once
    assign pre_wrap = (cur_ff.pre_cnt >= pre_top);
    assign div_wrap = (cur_ff.div_cnt >= cur_ff.divisor); // R01

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Write target from the held address; unmapped writes answer with an error
    always_comb begin
        wr_xmt_sel = 1'b0;
        wr_rcv_sel = 1'b0;
        wr_div_sel = 1'b0;
        case ({cur_ff.aw_addr[11:2], 2'b00})
            baud_gen_pkg::XMT_CTRL_ADDR: begin
                wr_xmt_sel = 1'b1;
            end
            baud_gen_pkg::RCV_CTRL_ADDR: begin
                wr_rcv_sel = 1'b1;
            end
            baud_gen_pkg::DIVISOR_ADDR: begin
                wr_div_sel = 1'b1;
            end
            default: begin
                wr_xmt_sel = 1'b0;
            end
        endcase
        wr_mapped = wr_xmt_sel | wr_rcv_sel | wr_div_sel;
        // Bit 1 mirrors the shift register, bit 3 stays zero
        xmt_wval = (cur_ff.w_data[7:0] & baud_gen_pkg::XMT_CTRL_WMASK)
            | {6'h00, shift_empty, 1'b0};
    end

    // Read word for the requested address; unmapped reads return zero
    always_comb begin
        rd_resp = baud_gen_pkg::RESP_OKAY;
        case ({s_axi_araddr[11:2], 2'b00})
            baud_gen_pkg::XMT_CTRL_ADDR: begin
                rd_word = {24'h000000, cur_ff.xmt_ctrl};
            end
            baud_gen_pkg::RCV_CTRL_ADDR: begin
                rd_word = {24'h000000, cur_ff.rcv_ctrl};
            end
            baud_gen_pkg::DIVISOR_ADDR: begin
                rd_word = 32'(cur_ff.divisor);
            end
            baud_gen_pkg::STATUS_ADDR: begin
                rd_word = {22'h0, cur_ff.level, 8'(cur_ff.div_cnt), 1'b0};
            end
            default: begin
                rd_word = 32'h00000000;
                rd_resp = baud_gen_pkg::RESP_SLVERR;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Receive vote
    // ------------------------------------------------------------
    // Two of three samples decide, so one stray sample cannot flip the level
    assign vote = (cur_ff.samples[0] & cur_ff.samples[1]) | // R11
                  (cur_ff.samples[1] & cur_ff.samples[2]) |
                  (cur_ff.samples[0] & cur_ff.samples[2]);

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    // A write commits once address and data are held and the last answer is gone
    assign do_write = cur_ff.aw_held && cur_ff.w_held && !cur_ff.bvalid;
    // A read is taken only while no read data is waiting
    assign do_read = s_axi_arvalid && !cur_ff.rvalid;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.tick = 1'b0;

        // Rate timer: prescale then divisor count, ticks every (X+1)*N
        if (running) begin
            if (pre_wrap) begin
                nxt_ff.pre_cnt = 6'h00;
                if (div_wrap) begin
                    nxt_ff.div_cnt = '0; // R15
                    nxt_ff.tick = 1'b1; // R13
                end else begin
                    nxt_ff.div_cnt = DIV_WIDTH'(cur_ff.div_cnt + 1'b1); // R15
                end
            end else begin
                nxt_ff.pre_cnt = 6'(cur_ff.pre_cnt + 6'h01);
            end
        end else begin
            nxt_ff.pre_cnt = 6'h00;
            nxt_ff.div_cnt = '0;
        end

        // Receive pin history and voted level
        nxt_ff.samples = {cur_ff.samples[VOTE_N-2:0], receive_data_pin};
        nxt_ff.level = vote;

        // Status bit follows the transmit shift register
        nxt_ff.xmt_ctrl[baud_gen_pkg::XMT_EMPTY_BIT] = shift_empty;

        // Write channel capture
        if (s_axi_awvalid && !cur_ff.aw_held) begin
            nxt_ff.aw_held = 1'b1;
            nxt_ff.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_ff.w_held) begin
            nxt_ff.w_held = 1'b1;
            nxt_ff.w_data = s_axi_wdata;
            nxt_ff.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_ff.aw_held = 1'b0;
            nxt_ff.w_held = 1'b0;
            nxt_ff.bvalid = 1'b1;
            if (wr_mapped) begin
                nxt_ff.bresp = baud_gen_pkg::RESP_OKAY;
            end else begin
                nxt_ff.bresp = baud_gen_pkg::RESP_SLVERR;
            end
            if (cur_ff.w_strb[0] && wr_xmt_sel) begin
                nxt_ff.xmt_ctrl = xmt_wval;
            end
            if (cur_ff.w_strb[0] && wr_rcv_sel) begin
                nxt_ff.rcv_ctrl = cur_ff.w_data[7:0] & baud_gen_pkg::RCV_CTRL_WMASK;
            end
            // New divisor restarts the count from zero
            if (cur_ff.w_strb[0] && wr_div_sel) begin
                nxt_ff.divisor = cur_ff.w_data[DIV_WIDTH-1:0]; // R09
                nxt_ff.div_cnt = '0; // R08
                nxt_ff.pre_cnt = 6'h00; // R08
                nxt_ff.tick = 1'b0;
            end
        end
        if (cur_ff.bvalid && s_axi_bready) begin
            nxt_ff.bvalid = 1'b0;
        end

        // Read channel: data is captured at the address handshake
        if (do_read) begin
            nxt_ff.rvalid = 1'b1;
            nxt_ff.rresp = rd_resp;
            nxt_ff.rdata = rd_word;
        end else if (cur_ff.rvalid && s_axi_rready) begin
            nxt_ff.rvalid = 1'b0;
        end

        if (rst) begin
            nxt_ff = '0;
            nxt_ff.xmt_ctrl = baud_gen_pkg::XMT_CTRL_RESET;
            nxt_ff.rcv_ctrl = baud_gen_pkg::RCV_CTRL_RESET;
            nxt_ff.divisor = baud_gen_pkg::DIVISOR_RESET; // R10
            nxt_ff.samples = '1;
            nxt_ff.level = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        cur_ff <= nxt_ff;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !cur_ff.aw_held;
    assign s_axi_wready = !cur_ff.w_held;
    assign s_axi_bvalid = cur_ff.bvalid;
    assign s_axi_bresp = cur_ff.bresp;
    assign s_axi_arready = !cur_ff.rvalid;
    assign s_axi_rvalid = cur_ff.rvalid;
    assign s_axi_rdata = cur_ff.rdata;
    assign s_axi_rresp = cur_ff.rresp;
    assign sample_tick = cur_ff.tick;
    assign rx_level = cur_ff.level;

endmodule : serial_baud_rate_generator

`default_nettype wire

// file: dv/baud_gen_props.sv
// Checker: port timing of the rate generator, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module baud_gen_props (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic receive_data_pin, // Receive pin
    input wire logic sample_tick, // Rate tick
    input wire logic rx_level // Voted level
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_tick_gap: assert property (sample_tick |=> !sample_tick [*3])
        else $error("tick period below four cycles");
    chk_vote_high: assert property (receive_data_pin [*6] |-> rx_level)
        else $error("voted level not high");
    chk_vote_low: assert property (!receive_data_pin [*6] |-> !rx_level)
        else $error("voted level not low");
    chk_vote_glitch: assert property ((!receive_data_pin [*6] ##1 receive_data_pin
        ##1 !receive_data_pin [*2]) |-> !rx_level [*4])
        else $error("single sample changed voted level");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
endmodule : baud_gen_props
bind serial_baud_rate_generator baud_gen_props baud_gen_props_inst (.clk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .receive_data_pin, .sample_tick, .rx_level);
`default_nettype wire

// file: dv/tb_top.sv
// Testbench: register access, rate periods and receive voting.
// Assumes the generator top module and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [11:0] DIV_A = baud_gen_pkg::DIVISOR_ADDR;
    localparam logic [11:0] XMT_A = baud_gen_pkg::XMT_CTRL_ADDR;
    localparam logic [11:0] STA_A = baud_gen_pkg::STATUS_ADDR;
    localparam logic [1:0] OK = baud_gen_pkg::RESP_OKAY;
    localparam logic [1:0] ER = baud_gen_pkg::RESP_SLVERR;
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, pin = 1'b1, shift_empty = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, tick, rx_level;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int errors = 0, total_checks = 0, cycles = 0, c, p;
    logic [7:0] ctl [6] = '{8'h00, 8'h04, 8'h90, 8'h94, 8'h04, 8'h10};
    logic [7:0] xv [6] = '{8'h01, 8'h00, 8'h05, 8'h05, 8'hFF, 8'h00};
    int nv [6] = '{64, 16, 4, 4, 16, 0};
    serial_baud_rate_generator serial_baud_rate_generator_inst (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .receive_data_pin(pin),
        .shift_empty(shift_empty), .sample_tick(tick), .rx_level(rx_level));
    always #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic final_report;
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge clk);
            if (!a_ok && awready) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, bresp});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
        input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rresp", {30'h0, r}, {30'h0, rresp});
        chk("rdata", e, rdata & m);
    endtask : rd
    task automatic wait_tick;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (tick !== 1'b1 && c < 20000);
    endtask : wait_tick
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(DIV_A, 32'h00, 32'hFFFFFFFF, OK);
        rd(XMT_A, 32'h02, 32'hFFFFFFFF, OK);
        rd(baud_gen_pkg::RCV_CTRL_ADDR, 32'h00, 32'hFFFFFFFF, OK);
        rd(12'h004, 32'h00, 32'hFFFFFFFF, ER);
        wr(12'h008, 32'h55, ER);
        wr(DIV_A, 32'hFF, OK);
        rd(DIV_A, 32'hFF, 32'hFFFFFFFF, OK);
        shift_empty <= 1'b0;
        wr(XMT_A, 32'h04, OK);
        rd(XMT_A, 32'h04, 32'hFFFFFFFF, OK);
        shift_empty <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            p = (int'(xv[i]) + 1) * nv[i];
            wr(XMT_A, {24'h0, ctl[i]}, OK);
            wr(DIV_A, {24'h0, xv[i]}, OK);
            if (nv[i] == 0) begin
                c = 0;
                repeat (300) begin
                    @(posedge clk);
                    if (tick !== 1'b0) begin
                        c++;
                    end
                end
                chk("slave_tick", 32'h0, c);
                continue;
            end
            wait_tick();
            chk("restart", 32'h1, {31'h0, c >= p - 3 && c <= p + 1});
            wait_tick();
            chk("period", p, c);
        end
        pin <= 1'b0;
        repeat (8) @(posedge clk);
        rd(STA_A, 32'h000, 32'h200, OK);
        pin <= 1'b1;
        @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        chk("glitch", 32'h0, {31'h0, rx_level});
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        rd(STA_A, 32'h200, 32'h200, OK);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
